// [sim/phy_station.sv]
// link partner model: carrier echo and commanded collision
`timescale 1ns/100ps
module phy_station (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mac_transmit_enable,
  input wire logic [15:0] coll_at,
  output logic mac_carrier_sense,
  output logic collision
);
  logic [15:0] cnt_reg;
  // collides on every attempt at the named clock cycle of enable, zero keeps the wire clean
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
      collision <= 1'b0;
    end else begin
      cnt_reg <= mac_transmit_enable ? cnt_reg + 16'h0001 : 16'h0000;
      collision <= mac_transmit_enable && coll_at != 16'h0000 && cnt_reg == coll_at;
    end
  end
  assign mac_carrier_sense = mac_transmit_enable || collision;
endmodule : phy_station

// [sim/testbench.sv]
// self-checking bench of the switch port mac
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [7:0] g3; logic [7:0] g4; logic [11:0] len; logic vlan; logic acc;} row_s;
  logic clk_sys = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, link_100 = 1'b1, full_duplex = 1'b1, tx_valid = 1'b0;
  logic rx_frame_end = 1'b0, rx_vlan = 1'b0, rx_broadcast = 1'b0, rx_multicast = 1'b0, rx_is_pause = 1'b0;
  logic dest_busy = 1'b0, rxq_full = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [11:0] tx_len = 12'h040, rx_len = 12'h040;
  logic [15:0] rx_pause_time = 16'h0000, coll_at = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mac_carrier_sense, collision;
  logic mac_transmit_enable, tx_ready, tx_sent, tx_dropped, rx_accept, rx_discard, paused, flow_active;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_kind, res;
  logic [31:0] s_axi_rdata;
  logic [15:0] tx_pause_time;
  logic [33:0] r;
  logic [1:0] drop;
  int err_total = 0, checks = 0, cyc = 0, lead, high, t0;
  row_s rows [9] = '{'{8'h00, 8'h00, 12'h03f, 1'b0, 1'b0}, '{8'h00, 8'h00, 12'h040, 1'b0, 1'b1},
    '{8'h00, 8'h00, 12'h5ee, 1'b0, 1'b1}, '{8'h00, 8'h00, 12'h5ef, 1'b0, 1'b0}, '{8'h00, 8'h00, 12'h5f2, 1'b1, 1'b1},
    '{8'h00, 8'h02, 12'h600, 1'b0, 1'b1}, '{8'h00, 8'h02, 12'h601, 1'b0, 1'b0}, '{8'h40, 8'h00, 12'h800, 1'b0, 1'b1},
    '{8'h40, 8'h00, 12'h801, 1'b0, 1'b0}};
  // short storm intervals keep the run brief
  port_mac_flow #(.STORM_100_CYC(200), .STORM_10_CYC(2000)) port_mac_flow_inst (.*);
  phy_station phy_station_inst (.*);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // handshakes sampled at the falling edge, released after the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    bh = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100 && !bh; n++) begin
      @(negedge clk_sys);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      if (bh) res = s_axi_bresp;
      @(posedge clk_sys);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [33:0] q);
    logic ah, got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100 && !got; n++) begin
      @(negedge clk_sys);
      ah = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      q = {s_axi_rresp, s_axi_rdata};
      @(posedge clk_sys);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic rx(input logic [11:0] l, input logic v, b, p, output logic [1:0] q);
    rx_len <= l;
    rx_vlan <= v;
    rx_broadcast <= b;
    rx_is_pause <= p;
    rx_frame_end <= 1'b1;
    @(posedge clk_sys);
    rx_frame_end <= 1'b0;
    @(negedge clk_sys);
    q = {rx_accept, rx_discard};
    @(posedge clk_sys);
  endtask : rx
  // lead counts idle cycles before the data frame, high its enable cycles
  task automatic send(output int ld, output int hi, output logic [1:0] dr);
    logic done;
    ld = 0;
    hi = 0;
    done = 1'b0;
    dr = 2'b00;
    tx_valid <= 1'b1;
    // ready is judged only at falling edges, never in the edge step that ends it
    for (int n = 0; n < 20000 && !done; n++) begin
      @(negedge clk_sys);
      if (mac_transmit_enable && tx_kind === 2'h0) hi++;
      else if (hi == 0) ld++;
      done = tx_ready === 1'b1;
      dr = {tx_sent, tx_dropped};
    end
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : send
  task automatic wait_txen(input logic lvl);
    for (int n = 0; n < 500 && mac_transmit_enable !== lvl; n++) @(negedge clk_sys);
  endtask : wait_txen
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(port_mac_pkg::OFF_RATE_LO, r);
    chk(r, 34'h00000004a);
    rd(port_mac_pkg::OFF_GLOBAL4, r);
    chk(r, 34'h0);
    rd(port_mac_pkg::OFF_GLOBAL3, r);
    chk(r, 34'h0);
    rd(8'h40, r);
    chk(r, {port_mac_pkg::RESP_SLVERR, 32'h0});
    wr(8'h40, 32'h0);
    chk({32'h0, res}, {32'h0, port_mac_pkg::RESP_SLVERR});
    $display("test reset done");
    foreach (rows[i]) begin
      wr(port_mac_pkg::OFF_GLOBAL3, {24'h0, rows[i].g3});
      wr(port_mac_pkg::OFF_GLOBAL4, {24'h0, rows[i].g4});
      rx(rows[i].len, rows[i].vlan, 1'b0, 1'b0, res);
      chk({32'h0, res}, {32'h0, rows[i].acc, !rows[i].acc});
    end
    $display("test length table done");
    send(lead, high, drop);
    chk(34'(high), 34'd128);
    chk({32'h0, drop}, 34'h2);
    send(lead, high, drop);
    // two idle cycles pass inside the previous send before lead starts counting
    chk(34'(lead + 2 >= 24), 34'h1);
    $display("test gap done");
    rx_pause_time <= 16'h0002;
    rx(12'h040, 1'b0, 1'b0, 1'b1, res);
    chk({33'h0, paused}, 34'h1);
    send(lead, high, drop);
    chk(34'(lead >= 250), 34'h1);
    rx_pause_time <= 16'h0004;
    rx(12'h040, 1'b0, 1'b0, 1'b1, res);
    rx_pause_time <= 16'h0001;
    rx(12'h040, 1'b0, 1'b0, 1'b1, res);
    repeat (140) @(posedge clk_sys);
    chk({33'h0, paused}, 34'h0);
    $display("test pause done");
    dest_busy <= 1'b1;
    rx(12'h040, 1'b0, 1'b0, 1'b0, res);
    wait_txen(1'b1);
    chk({16'h0, tx_kind, tx_pause_time}, {16'h0, 2'h1, 16'hffff});
    @(posedge clk_sys);
    dest_busy <= 1'b0;
    repeat (50) @(posedge clk_sys);
    chk({33'h0, flow_active}, 34'h1);
    wait_txen(1'b0);
    wait_txen(1'b1);
    chk({16'h0, tx_kind, tx_pause_time}, {16'h0, 2'h1, 16'h0000});
    $display("test flow control done");
    @(posedge clk_sys);
    full_duplex <= 1'b0;
    tx_len <= 12'h100;
    coll_at <= 16'd200;
    send(lead, high, drop);
    chk({32'h0, drop}, 34'h1);
    wr(port_mac_pkg::OFF_GLOBAL3, 32'h1);
    coll_at <= 16'd10;
    send(lead, high, drop);
    chk({32'h0, drop}, 34'h1);
    coll_at <= 16'h0000;
    $display("test collision done");
    wr(port_mac_pkg::OFF_GLOBAL4, 32'h20);
    rxq_full <= 1'b1;
    wait_txen(1'b1);
    chk({33'h0, flow_active}, 34'h1);
    chk({31'h0, mac_transmit_enable, tx_kind}, 34'h6);
    repeat (990) @(posedge clk_sys);
    wait_txen(1'b0);
    chk({33'h0, mac_transmit_enable}, 34'h0);
    wait_txen(1'b1);
    chk({31'h0, mac_transmit_enable, tx_kind}, 34'h6);
    @(posedge clk_sys);
    send(lead, high, drop);
    chk({32'h0, drop}, 34'h2);
    wait_txen(1'b1);
    chk({31'h0, mac_transmit_enable, tx_kind}, 34'h6);
    @(posedge clk_sys);
    coll_at <= 16'd10;
    t0 = cyc;
    send(lead, high, drop);
    // sixteen attempts with no backoff fit well inside this bound, with backoff they do not
    chk({32'h0, drop}, 34'h1);
    chk(34'(cyc - t0 < 1000), 34'h1);
    rxq_full <= 1'b0;
    coll_at <= 16'h0000;
    $display("test back pressure done");
    wr(port_mac_pkg::OFF_RATE_LO, 32'h2);
    wr(port_mac_pkg::OFF_STORM, 32'h1);
    res = 2'b10;
    for (int i = 0; i < 6 && res !== 2'b01; i++) rx(12'h040, 1'b0, 1'b1, 1'b0, res);
    // line up with an interval start so no boundary falls between the next frames
    for (int i = 0; i < 120 && res !== 2'b10; i++) rx(12'h040, 1'b0, 1'b1, 1'b0, res);
    rx(12'h040, 1'b0, 1'b1, 1'b0, res);
    chk({32'h0, res}, 34'h2);
    rx(12'h040, 1'b0, 1'b1, 1'b0, res);
    chk({32'h0, res}, 34'h1);
    repeat (210) @(posedge clk_sys);
    rx(12'h040, 1'b0, 1'b1, 1'b0, res);
    chk({32'h0, res}, 34'h2);
    $display("test storm done");
    link_100 <= 1'b0;
    send(lead, high, drop);
    // first nibble tick may land anywhere in the divide-by-ten phase
    chk(34'(high > 5100 && high <= 5120), 34'h1);
    $display("test slow link done");
    results();
  end
endmodule : testbench

// [verilog/port_mac_flow.sv]
// per-port mac: gap, backoff, length filter, pause, back pressure, storm limit
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module port_mac_flow #(
  parameter int STORM_100_CYC = port_mac_pkg::STORM_100_CYC,
  parameter int STORM_10_CYC = port_mac_pkg::STORM_10_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_100,
  input wire logic full_duplex,
  input wire logic mac_carrier_sense,
  input wire logic collision,
  output logic mac_transmit_enable,
  output logic [1:0] tx_kind,
  output logic [15:0] tx_pause_time,
  input wire logic tx_valid,
  input wire logic [11:0] tx_len,
  output logic tx_ready,
  output logic tx_sent,
  output logic tx_dropped,
  input wire logic rx_frame_end,
  input wire logic [11:0] rx_len,
  input wire logic rx_vlan,
  input wire logic rx_broadcast,
  input wire logic rx_multicast,
  input wire logic rx_is_pause,
  input wire logic [15:0] rx_pause_time,
  input wire logic dest_busy,
  input wire logic rxq_full,
  output logic rx_accept,
  output logic rx_discard,
  output logic paused,
  output logic flow_active
);
  typedef struct packed {
    port_mac_pkg::tx_state_e tx_st;
    port_mac_pkg::tx_kind_e kind;
    logic [15:0] quanta;
    logic [3:0] nib_div;
    logic [13:0] gap;
    logic [13:0] sent;
    logic [13:0] frame_nib;
    logic coll_flag;
    logic [4:0] coll_n;
    logic [9:0] bo_slots;
    logic [6:0] bo_sub;
    logic [15:0] lfsr;
    logic [9:0] bp_cnt;
    logic [15:0] pause_q;
    logic [6:0] pause_sub;
    logic fc_on;
    logic [7:0] hold;
    logic xoff_pend;
    logic xon_pend;
    logic [23:0] storm_cnt;
    logic [10:0] storm_frames;
    logic rx_acc;
    logic rx_dis;
    logic sent_p;
    logic drop_p;
    logic ack_p;
    logic [7:0] g3;
    logic [7:0] g4;
    logic [7:0] rate_hi;
    logic [7:0] rate_lo;
    logic [1:0] storm_ctl;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s s_reg;
  state_s s_next;

  logic nt;
  logic can_go;
  logic bp_want;
  logic half;
  logic [3:0] bo_exp;
  logic [9:0] bo_mask;
  logic [11:0] max_len;
  logic [10:0] storm_limit;
  logic storm_frame;
  logic [23:0] storm_last;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  // 25 mhz clock: one nibble per cycle at 100 mb/s, one per ten at 10 mb/s
  assign nt = link_100 || (s_reg.nib_div == port_mac_pkg::NIB_DIV_10M);
  assign half = !full_duplex;
  assign can_go = s_reg.gap >= port_mac_pkg::IPG_NIB;
  assign bp_want = half && s_reg.g4[port_mac_pkg::G4_BP_EN] && s_reg.fc_on;
  assign storm_limit = {s_reg.rate_hi[2:0], s_reg.rate_lo};
  assign storm_last = link_100 ? 24'(STORM_100_CYC - 1) : 24'(STORM_10_CYC - 1);
  assign storm_frame = s_reg.storm_ctl[port_mac_pkg::ST_EN] &&
                       (rx_broadcast || (rx_multicast && s_reg.storm_ctl[port_mac_pkg::ST_MCAST]));
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  assign mac_transmit_enable = (s_reg.tx_st == port_mac_pkg::TX_SEND) || (s_reg.tx_st == port_mac_pkg::TX_BP);
  assign tx_kind = s_reg.kind;
  assign tx_pause_time = s_reg.quanta;
  assign tx_ready = s_reg.ack_p;
  assign tx_sent = s_reg.sent_p;
  assign tx_dropped = s_reg.drop_p;
  assign rx_accept = s_reg.rx_acc;
  assign rx_discard = s_reg.rx_dis;
  assign paused = s_reg.pause_q != 16'h0000;
  assign flow_active = s_reg.fc_on;
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  always_comb begin
    bo_exp = (s_reg.coll_n[4] || s_reg.coll_n[3:0] > port_mac_pkg::EXP_CAP) ? port_mac_pkg::EXP_CAP : s_reg.coll_n[3:0];
    if (s_reg.g3[port_mac_pkg::G3_AGGR] && bo_exp > port_mac_pkg::AGGR_CAP) begin
      // aggressive mode caps the window low so our port wins the wire sooner
      bo_exp = port_mac_pkg::AGGR_CAP;
    end
    bo_mask = 10'((11'h001 << bo_exp) - 11'h001);
    if (s_reg.g3[port_mac_pkg::G3_LARGE]) begin
      max_len = port_mac_pkg::LARGE_MAX_LEN;
    end else if (s_reg.g4[port_mac_pkg::G4_LEGAL1536]) begin
      max_len = port_mac_pkg::LEGAL_MAX_LEN;
    end else begin
      max_len = port_mac_pkg::STD_MAX_LEN;
    end
    if (rx_vlan) begin
      max_len = max_len + port_mac_pkg::VLAN_EXTRA;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.sent_p = 1'b0;
    s_next.drop_p = 1'b0;
    s_next.ack_p = 1'b0;
    s_next.rx_acc = 1'b0;
    s_next.rx_dis = 1'b0;
    s_next.nib_div = (link_100 || nt) ? 4'h0 : s_reg.nib_div + 4'h1;
    s_next.lfsr = {s_reg.lfsr[14:0], s_reg.lfsr[15] ^ s_reg.lfsr[13] ^ s_reg.lfsr[12] ^ s_reg.lfsr[10] ^ 1'b1};

    // gap restarts while sending, and after a collision while carrier is seen
    if (mac_transmit_enable || (s_reg.coll_flag && mac_carrier_sense)) begin
      s_next.gap = 14'h0000;
    end else if (nt && !can_go) begin
      s_next.gap = s_reg.gap + 14'h0001;
    end

    unique case (s_reg.tx_st)
      port_mac_pkg::TX_IDLE: begin
        s_next.sent = 14'h0000;
        s_next.bp_cnt = 10'h000;
        if (can_go) begin
          if (full_duplex && (s_reg.xoff_pend || s_reg.xon_pend)) begin
            s_next.tx_st = port_mac_pkg::TX_SEND;
            s_next.kind = port_mac_pkg::KIND_PAUSE;
            s_next.quanta = s_reg.xoff_pend ? port_mac_pkg::PAUSE_MAX : 16'h0000;
            s_next.frame_nib = 14'({port_mac_pkg::PAUSE_LEN, 1'b0});
            s_next.xoff_pend = 1'b0;
            s_next.xon_pend = 1'b0;
            s_next.coll_flag = 1'b0;
          end else if (tx_valid && !paused) begin
            s_next.tx_st = port_mac_pkg::TX_SEND;
            s_next.kind = port_mac_pkg::KIND_DATA;
            s_next.quanta = 16'h0000;
            s_next.frame_nib = 14'({tx_len, 1'b0});
            s_next.coll_flag = 1'b0;
          end else if (bp_want && !tx_valid) begin
            s_next.tx_st = port_mac_pkg::TX_BP;
            s_next.kind = port_mac_pkg::KIND_PREAMBLE;
            s_next.coll_flag = 1'b0;
          end
        end
      end
      port_mac_pkg::TX_SEND: begin
        if (nt) begin
          s_next.sent = s_reg.sent + 14'h0001;
        end
        if (collision && half) begin
          s_next.coll_flag = 1'b1;
          s_next.tx_st = port_mac_pkg::TX_IDLE;
          if (s_reg.sent >= port_mac_pkg::LATE_NIB) begin
            s_next.drop_p = 1'b1;
            s_next.ack_p = 1'b1;
            s_next.coll_n = 5'h00;
          end else if (s_reg.coll_n == port_mac_pkg::MAX_COLL - 5'h01 &&
                       !s_reg.g4[port_mac_pkg::G4_NO_DROP]) begin
            s_next.drop_p = 1'b1;
            s_next.ack_p = 1'b1;
            s_next.coll_n = 5'h00;
          end else begin
            // no-drop keeps retrying with the count pinned at its top
            s_next.coll_n = (s_reg.coll_n == port_mac_pkg::MAX_COLL) ? s_reg.coll_n : s_reg.coll_n + 5'h01;
            if (!bp_want) begin
              s_next.tx_st = port_mac_pkg::TX_BACKOFF;
              s_next.bo_slots = 10'h000;
              s_next.bo_sub = 7'h00;
            end
          end
        end else if (nt && s_reg.sent + 14'h0001 >= s_reg.frame_nib) begin
          s_next.tx_st = port_mac_pkg::TX_IDLE;
          if (s_reg.kind == port_mac_pkg::KIND_DATA) begin
            s_next.sent_p = 1'b1;
            s_next.ack_p = 1'b1;
            s_next.coll_n = 5'h00;
          end
        end
      end
      port_mac_pkg::TX_BACKOFF: begin
        // slot count drawn on the first cycle, from the window of the current count
        if (s_reg.bo_sub == 7'h00 && s_reg.bo_slots == 10'h000 && !s_reg.sent[13]) begin
          s_next.bo_slots = s_reg.lfsr[9:0] & bo_mask;
          s_next.sent = 14'h2000;
          if ((s_reg.lfsr[9:0] & bo_mask) == 10'h000) begin
            s_next.tx_st = port_mac_pkg::TX_IDLE;
          end
        end else if (nt) begin
          s_next.bo_sub = s_reg.bo_sub + 7'h01;
          if (s_reg.bo_sub == port_mac_pkg::SLOT_NIB_LAST) begin
            s_next.bo_slots = s_reg.bo_slots - 10'h001;
            if (s_reg.bo_slots == 10'h001) begin
              s_next.tx_st = port_mac_pkg::TX_IDLE;
            end
          end
        end
      end
      port_mac_pkg::TX_BP: begin
        // collisions are ignored here: carrier simply stays up
        if (tx_valid || !bp_want) begin
          s_next.tx_st = port_mac_pkg::TX_IDLE;
        end else if (nt) begin
          s_next.bp_cnt = s_reg.bp_cnt + 10'h001;
          if (s_reg.bp_cnt == port_mac_pkg::BP_ON_NIB) begin
            // idle gap is the short silence that avoids jabber and deferral limits
            s_next.tx_st = port_mac_pkg::TX_IDLE;
          end
        end
      end
    endcase

    // pause timer in units of 512 bit times
    if (rx_frame_end && rx_is_pause && full_duplex) begin
      s_next.pause_q = rx_pause_time;
      s_next.pause_sub = 7'h00;
    end else if (paused && nt) begin
      s_next.pause_sub = s_reg.pause_sub + 7'h01;
      if (s_reg.pause_sub == port_mac_pkg::SLOT_NIB_LAST) begin
        s_next.pause_q = s_reg.pause_q - 16'h0001;
      end
    end

    // flow control on/off with a hold time before release
    if ((rx_frame_end && dest_busy) || rxq_full) begin
      s_next.hold = 8'h00;
      if (!s_reg.fc_on) begin
        s_next.fc_on = 1'b1;
        s_next.xoff_pend = full_duplex;
        s_next.xon_pend = 1'b0;
      end
    end else if (s_reg.fc_on && !dest_busy) begin
      s_next.hold = s_reg.hold + 8'h01;
      if (s_reg.hold == port_mac_pkg::FC_HOLD - 8'h01) begin
        s_next.fc_on = 1'b0;
        s_next.xon_pend = full_duplex;
        s_next.xoff_pend = 1'b0;
        s_next.hold = 8'h00;
      end
    end else begin
      s_next.hold = 8'h00;
    end

    // storm interval and length filter
    if (s_reg.storm_cnt >= storm_last) begin
      s_next.storm_cnt = 24'h000000;
      s_next.storm_frames = 11'h000;
    end else begin
      s_next.storm_cnt = s_reg.storm_cnt + 24'h000001;
    end
    if (rx_frame_end) begin
      if (rx_len < port_mac_pkg::MIN_LEN || rx_len > max_len || rx_is_pause) begin
        s_next.rx_dis = 1'b1;
      end else if (storm_frame && s_reg.storm_frames >= storm_limit) begin
        s_next.rx_dis = 1'b1;
      end else begin
        s_next.rx_acc = 1'b1;
        if (storm_frame && s_reg.storm_cnt < storm_last) begin
          s_next.storm_frames = s_reg.storm_frames + 11'h001;
        end
      end
    end

    // register bus slave
    s_next.wen = 1'b0;
    if (aw_hs) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wen = s_axi_wstrb[0];
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = port_mac_pkg::RESP_OKAY;
      unique case (s_reg.awaddr)
        port_mac_pkg::OFF_GLOBAL3: if (s_reg.wen) s_next.g3 = s_reg.wdata;
        port_mac_pkg::OFF_GLOBAL4: if (s_reg.wen) s_next.g4 = s_reg.wdata;
        port_mac_pkg::OFF_RATE_HI: if (s_reg.wen) s_next.rate_hi = s_reg.wdata;
        port_mac_pkg::OFF_RATE_LO: if (s_reg.wen) s_next.rate_lo = s_reg.wdata;
        port_mac_pkg::OFF_STORM: if (s_reg.wen) s_next.storm_ctl = s_reg.wdata[1:0];
        port_mac_pkg::OFF_STATUS: s_next.bresp = port_mac_pkg::RESP_OKAY;
        default: s_next.bresp = port_mac_pkg::RESP_SLVERR;
      endcase
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (ar_hs) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = port_mac_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        port_mac_pkg::OFF_GLOBAL3: s_next.rdata = {24'h000000, s_reg.g3};
        port_mac_pkg::OFF_GLOBAL4: s_next.rdata = {24'h000000, s_reg.g4};
        port_mac_pkg::OFF_RATE_HI: s_next.rdata = {24'h000000, s_reg.rate_hi};
        port_mac_pkg::OFF_RATE_LO: s_next.rdata = {24'h000000, s_reg.rate_lo};
        port_mac_pkg::OFF_STORM: s_next.rdata = {30'h00000000, s_reg.storm_ctl};
        port_mac_pkg::OFF_STATUS: s_next.rdata = {s_reg.pause_q, 5'h00, s_reg.storm_frames};
        default: begin
          s_next.rdata = 32'h00000000;
          s_next.rresp = port_mac_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.rate_lo <= port_mac_pkg::RATE_LO_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence early_coll_s;
    s_reg.tx_st == port_mac_pkg::TX_SEND && collision && half && s_reg.sent < port_mac_pkg::LATE_NIB;
  endsequence
  sequence bp_coll_s;
    early_coll_s ##0 bp_want ##0 (s_reg.coll_n < port_mac_pkg::MAX_COLL - 5'h01);
  endsequence

  ipg_gap_a: assert property ($rose(mac_transmit_enable) |-> $past(s_reg.gap) >= port_mac_pkg::IPG_NIB)
    else $error("transmit enable raised before the interframe gap");
  late_drop_a: assert property ((s_reg.tx_st == port_mac_pkg::TX_SEND && collision && half &&
    s_reg.sent >= port_mac_pkg::LATE_NIB) |=> tx_dropped && tx_ready && s_reg.tx_st == port_mac_pkg::TX_IDLE)
    else $error("late collision did not drop the frame");
  excess_drop_a: assert property ((early_coll_s ##0 s_reg.coll_n == 5'h0f &&
    !s_reg.g4[port_mac_pkg::G4_NO_DROP]) |=> tx_dropped)
    else $error("sixteenth collision did not drop the frame");
  pause_hold_a: assert property ((s_reg.tx_st == port_mac_pkg::TX_IDLE && paused) |=>
    !(s_reg.tx_st == port_mac_pkg::TX_SEND && s_reg.kind == port_mac_pkg::KIND_DATA))
    else $error("normal frame started while paused");
  pause_reload_a: assert property ((rx_frame_end && rx_is_pause && full_duplex) |=>
    s_reg.pause_q == $past(rx_pause_time))
    else $error("pause timer not loaded from the newer frame");
  short_drop_a: assert property ((rx_frame_end && rx_len < port_mac_pkg::MIN_LEN) |=> rx_discard && !rx_accept)
    else $error("short frame was not dropped");
  xoff_pend_a: assert property (($rose(s_reg.fc_on) && $past(full_duplex)) |-> s_reg.xoff_pend && !s_reg.xon_pend)
    else $error("flow control on without an off pause queued");
  fc_hyst_a: assert property ($fell(s_reg.fc_on) |-> $past(s_reg.hold) == port_mac_pkg::FC_HOLD - 8'h01)
    else $error("flow control released before the hold time");
  bp_skip_a: assert property (bp_coll_s |=> s_reg.tx_st == port_mac_pkg::TX_IDLE ##1
    s_reg.tx_st != port_mac_pkg::TX_BACKOFF)
    else $error("backoff taken during back pressure");
  storm_clear_a: assert property ((s_reg.storm_cnt >= storm_last) |=> s_reg.storm_frames == 11'h000)
    else $error("storm counter not cleared at interval start");
  storm_drop_a: assert property ((rx_frame_end && storm_frame && s_reg.storm_frames >= storm_limit) |=>
    rx_discard)
    else $error("storm frame over the limit was accepted");
endmodule : port_mac_flow

// [verilog/port_mac_pkg.sv]
// constants, register map and types of the switch port mac
package port_mac_pkg;
  localparam logic [7:0] OFF_GLOBAL3 = 8'h0c;
  localparam logic [7:0] OFF_GLOBAL4 = 8'h10;
  localparam logic [7:0] OFF_RATE_HI = 8'h18;
  localparam logic [7:0] OFF_RATE_LO = 8'h1c;
  localparam logic [7:0] OFF_STORM = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam int G3_AGGR = 0;
  localparam int G3_LARGE = 6;
  localparam int G4_LEGAL1536 = 1;
  localparam int G4_NO_DROP = 3;
  localparam int G4_BP_EN = 5;
  localparam int ST_EN = 0;
  localparam int ST_MCAST = 1;
  localparam logic [7:0] RATE_LO_RST = 8'h4a;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IPG_BITS = 96;
  localparam int SLOT_BITS = 512;
  localparam logic [13:0] IPG_NIB = 14'(IPG_BITS / 4);
  localparam logic [13:0] LATE_NIB = 14'(SLOT_BITS / 4);
  localparam logic [6:0] SLOT_NIB_LAST = 7'(SLOT_BITS / 4 - 1);
  localparam logic [3:0] NIB_DIV_10M = 4'h9;
  localparam logic [4:0] MAX_COLL = 5'h10;
  localparam logic [3:0] EXP_CAP = 4'ha;
  localparam logic [3:0] AGGR_CAP = 4'h3;
  localparam logic [11:0] MIN_LEN = 12'h040;
  localparam logic [11:0] STD_MAX_LEN = 12'h5ee;
  localparam logic [11:0] LEGAL_MAX_LEN = 12'h600;
  localparam logic [11:0] LARGE_MAX_LEN = 12'h800;
  localparam logic [11:0] VLAN_EXTRA = 12'h004;
  localparam logic [11:0] PAUSE_LEN = 12'h040;
  localparam logic [15:0] PAUSE_MAX = 16'hffff;
  localparam logic [9:0] BP_ON_NIB = 10'h3e8;
  localparam logic [7:0] FC_HOLD = 8'h64;
  localparam int CLK_KHZ = 25000;
  localparam int STORM_100_MS = 50;
  localparam int STORM_10_MS = 500;
  localparam int STORM_100_CYC = CLK_KHZ * STORM_100_MS;
  localparam int STORM_10_CYC = CLK_KHZ * STORM_10_MS;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_BACKOFF, TX_BP} tx_state_e;
  typedef enum logic [1:0] {KIND_DATA, KIND_PAUSE, KIND_PREAMBLE} tx_kind_e;
endpackage : port_mac_pkg
